/* File: fmf_frame_ctrl.sv */
/*
  Frame-format controller of an FM multiplex data decoder: AXI4-Lite register
  slave, frame-method decode, serial block parsing, frame position tracking,
  status bytes and a level interrupt.
  Assumes clk, synchronous active-high reset and ce shared with the decoder core,
  and received bits already synchronous to clk.
*/
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps

// Overview of operation
// - After reset the control bits select method B.
// - The block never guesses the frame method itself; only software writes of the control bits change it.
// - With halt low, interleave and real-time high is method A, interleave high alone is A', interleave low is B.
// - With halt high the block runs method C, block data only, ignoring the other bits and skipping vertical correction.
// - In method C the frame sync, frame head and real-time flags of the first status byte read as zero.
// - In method C the parity flag and the whole block number status byte read as zero.
// - Data blocks 1 to 60 carry the third code, 61 to 130 the second and 131 to 190 the first.
// - Vertical parity groups of 20, 21, 21 and 20 blocks follow, separated by 4 real-time blocks of the second code.
// - Real-time blocks get horizontal correction but never vertical correction.
// - Vertical correction spans 272 packets per frame, leaving out the 12 real-time packets.
// - A frame is 284 block periods of 18 ms, 5.112 s in all.
module fmf_frame_ctrl #(
  parameter int          BLOCK_PERIOD_CYC = fmf_pkg::BLOCK_PERIOD_CYC_DEF,
  parameter logic [15:0] BIC1_CODE        = 16'h1111,
  parameter logic [15:0] BIC2_CODE        = 16'h2222,
  parameter logic [15:0] BIC3_CODE        = 16'h3333,
  parameter logic [15:0] BIC4_CODE        = 16'h4444
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       ce,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [fmf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [fmf_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  input  wire logic                       bit_valid,
  input  wire logic                       bit_data,
  output logic                            block_done,
  output logic [7:0]                      first_status_byte,
  output logic [7:0]                      block_number_status_byte,
  output logic                            vert_correct_en,
  output logic                            interleave_en,
  output fmf_pkg::fmf_method_t            method,
  output logic                            irq
);
  import fmf_pkg::*;

  localparam int TMR_W = $clog2(BLOCK_PERIOD_CYC + 1);

  function automatic logic [2:0] bic_class(input logic [15:0] code);
    bic_class = 3'h0;
    if (code == BIC1_CODE) bic_class = 3'h1;
    if (code == BIC2_CODE) bic_class = 3'h2;
    if (code == BIC3_CODE) bic_class = 3'h3;
    if (code == BIC4_CODE) bic_class = 3'h4;
  endfunction

  function automatic fmf_method_t decode_method(input logic [2:0] c);
    if (c[CTRL_HALT_BIT]) decode_method = METH_C;
    else if (!c[CTRL_INTERLEAVE_BIT]) decode_method = METH_B;
    else if (c[CTRL_REALTIME_BIT]) decode_method = METH_A;
    else decode_method = METH_A2;
  endfunction

  // Bus and interrupt state.
  logic                    aw_held_ff, nxt_aw_held;
  logic                    w_held_ff, nxt_w_held;
  logic [AXI_AW-1:0]       waddr_ff, nxt_waddr;
  logic [7:0]              wbyte_ff, nxt_wbyte;
  logic                    wlane_ff, nxt_wlane;
  logic                    awready_ff, nxt_awready;
  logic                    wready_ff, nxt_wready;
  logic                    bvalid_ff, nxt_bvalid;
  logic [1:0]              bresp_ff, nxt_bresp;
  logic                    arready_ff, nxt_arready;
  logic                    rvalid_ff, nxt_rvalid;
  logic [31:0]             rdata_ff, nxt_rdata;
  logic [1:0]              rresp_ff, nxt_rresp;
  logic [2:0]              ctrl_ff, nxt_ctrl;
  logic [EV_N-1:0]         irq_stat_ff, nxt_irq_stat;
  logic [EV_N-1:0]         irq_mask_ff, nxt_irq_mask;
  logic                    irq_ff, nxt_irq;
  logic [EV_N-1:0]         events;

  // Link and frame state.
  fmf_parse_t              pstate_ff, nxt_pstate;
  logic [CNT_W-1:0]        bitcnt_ff, nxt_bitcnt;
  logic [15:0]             idsr_ff, nxt_idsr;
  logic [2:0]              cls_ff, nxt_cls;
  logic [2:0]              prev_cls_ff, nxt_prev_cls;
  logic [POS_W-1:0]        pos_ff, nxt_pos;
  logic                    synced_ff, nxt_synced;
  logic [TMR_W-1:0]        tmr_ff, nxt_tmr;
  logic                    done_ff, nxt_done;
  logic [7:0]              fs_ff, nxt_fs;
  logic [7:0]              num_ff, nxt_num;
  logic                    vce_ff, nxt_vce;
  logic                    ilv_ff, nxt_ilv;
  fmf_method_t             meth_ff, nxt_meth;
  logic                    blk_end;
  logic                    is_head;
  logic [POS_W-1:0]        cand_pos;
  fmf_kind_t               kind;
  logic [2:0]              exp_code;
  logic [7:0]              number;

  fmf_frame_map u_map (
    .pos      (cand_pos),
    .kind     (kind),
    .exp_code (exp_code),
    .number   (number)
  );

  always_comb begin
    nxt_pstate   = pstate_ff;
    nxt_bitcnt   = bitcnt_ff;
    nxt_idsr     = idsr_ff;
    nxt_cls      = cls_ff;
    blk_end      = 1'b0;
    if (bit_valid) begin
      nxt_bitcnt = bitcnt_ff + 8'h01;
      case (pstate_ff)
        PS_ID: begin
          nxt_idsr = {idsr_ff[14:0], bit_data};
          if (bitcnt_ff == CNT_W'(ID_BITS - 1)) begin
            nxt_pstate = PS_INFO;
            nxt_bitcnt = 8'h00;
            nxt_cls    = bic_class({idsr_ff[14:0], bit_data});
          end
        end
        PS_INFO: begin
          if (bitcnt_ff == CNT_W'(INFO_BITS - 1)) begin
            nxt_pstate = PS_CRC;
            nxt_bitcnt = 8'h00;
          end
        end
        PS_CRC: begin
          if (bitcnt_ff == CNT_W'(CRC_BITS - 1)) begin
            nxt_pstate = PS_PAR;
            nxt_bitcnt = 8'h00;
          end
        end
        default: begin
          if (bitcnt_ff == CNT_W'(HPAR_BITS - 1)) begin
            nxt_pstate = PS_ID;
            nxt_bitcnt = 8'h00;
            blk_end    = 1'b1;
          end
        end
      endcase
    end

    // A third-code block right after a parity block marks the frame head.
    is_head  = (cls_ff == 3'h3) && (prev_cls_ff == 3'h4);
    cand_pos = is_head ? '0 : (pos_ff == POS_W'(FRAME_BLOCKS - 1)) ? '0 : pos_ff + 9'h001;

    nxt_meth     = decode_method(ctrl_ff);
    nxt_ilv      = (nxt_meth == METH_B);
    nxt_done     = blk_end;
    nxt_prev_cls = prev_cls_ff;
    nxt_pos      = pos_ff;
    nxt_synced   = synced_ff;
    nxt_fs       = fs_ff;
    nxt_num      = num_ff;
    nxt_vce      = vce_ff;
    nxt_tmr      = (tmr_ff == TMR_W'(BLOCK_PERIOD_CYC)) ? tmr_ff : tmr_ff + 1'b1;
    events       = '0;
    // A link with no block end for one block period drops frame lock.
    if (tmr_ff == TMR_W'(BLOCK_PERIOD_CYC - 1)) begin
      events[EV_TIMEOUT] = 1'b1;
      nxt_synced         = 1'b0;
    end
    if (blk_end) begin
      events[EV_BLOCK] = 1'b1;
      nxt_tmr          = '0;
      nxt_prev_cls     = cls_ff;
      nxt_pos          = cand_pos;
      if (is_head) begin
        events[EV_HEAD] = 1'b1;
        nxt_synced      = 1'b1;
      end else if (synced_ff && cls_ff != exp_code) begin
        events[EV_SYNC] = 1'b1;
        nxt_synced      = 1'b0;
      end
      nxt_fs                = 8'h00;
      nxt_num               = 8'h00;
      nxt_vce               = (nxt_meth != METH_C) && (kind != KIND_REALTIME_INFO_BLOCK);
      if (nxt_meth != METH_C) begin
        nxt_fs[FS_SYNC_BIT]   = nxt_synced;
        nxt_fs[FS_HEAD_BIT]   = (cand_pos == '0);
        nxt_fs[FS_REALTIME_INFO_BLOCK_BIT]   = (kind == KIND_REALTIME_INFO_BLOCK);
        nxt_fs[FS_PARITY_BIT] = (kind == KIND_PARITY);
        nxt_num               = number;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pstate_ff   <= PS_ID;
      bitcnt_ff   <= '0;
      idsr_ff     <= '0;
      cls_ff      <= '0;
      prev_cls_ff <= '0;
      pos_ff      <= '0;
      synced_ff   <= 1'b0;
      tmr_ff      <= '0;
      done_ff     <= 1'b0;
      fs_ff       <= '0;
      num_ff      <= '0;
      vce_ff      <= 1'b0;
      ilv_ff      <= 1'b1;
      meth_ff     <= METH_B;
    end else if (ce) begin
      pstate_ff   <= nxt_pstate;
      bitcnt_ff   <= nxt_bitcnt;
      idsr_ff     <= nxt_idsr;
      cls_ff      <= nxt_cls;
      prev_cls_ff <= nxt_prev_cls;
      pos_ff      <= nxt_pos;
      synced_ff   <= nxt_synced;
      tmr_ff      <= nxt_tmr;
      done_ff     <= nxt_done;
      fs_ff       <= nxt_fs;
      num_ff      <= nxt_num;
      vce_ff      <= nxt_vce;
      ilv_ff      <= nxt_ilv;
      meth_ff     <= nxt_meth;
    end
  end

  always_comb begin
    nxt_aw_held  = aw_held_ff;
    nxt_w_held   = w_held_ff;
    nxt_waddr    = waddr_ff;
    nxt_wbyte    = wbyte_ff;
    nxt_wlane    = wlane_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_stat = irq_stat_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_wbyte  = s_axi_wdata[7:0];
      nxt_wlane  = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) nxt_bvalid = 1'b0;
    if (aw_held_ff && w_held_ff && !bvalid_ff) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = RESP_OKAY;
      case (waddr_ff)
        ADDR_CTRL:     if (wlane_ff) nxt_ctrl = wbyte_ff[2:0];
        ADDR_IRQ_MASK: if (wlane_ff) nxt_irq_mask = wbyte_ff[EV_N-1:0];
        ADDR_STATE, ADDR_IRQ_STAT: nxt_bresp = RESP_OKAY;
        default:       nxt_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) nxt_rvalid = 1'b0;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_CTRL:     nxt_rdata[2:0] = ctrl_ff;
        ADDR_STATE:    nxt_rdata = {15'h0000, pos_ff, 5'h00, synced_ff, meth_ff};
        ADDR_IRQ_MASK: nxt_rdata[EV_N-1:0] = irq_mask_ff;
        ADDR_IRQ_STAT: begin
          nxt_rdata[EV_N-1:0] = irq_stat_ff;
          nxt_irq_stat        = '0;
        end
        default:       nxt_rresp = RESP_SLVERR;
      endcase
    end
    // A new event beats a clear-on-read in the same cycle.
    nxt_irq_stat = nxt_irq_stat | (ce ? events : '0);
    nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
    nxt_awready  = !nxt_aw_held && !nxt_bvalid;
    nxt_wready   = !nxt_w_held && !nxt_bvalid;
    nxt_arready  = !nxt_rvalid;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_ff  <= 1'b0;
      w_held_ff   <= 1'b0;
      waddr_ff    <= '0;
      wbyte_ff    <= '0;
      wlane_ff    <= 1'b0;
      awready_ff  <= 1'b0;
      wready_ff   <= 1'b0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= RESP_OKAY;
      arready_ff  <= 1'b0;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= '0;
      rresp_ff    <= RESP_OKAY;
      ctrl_ff     <= CTRL_RST;
      irq_stat_ff <= '0;
      irq_mask_ff <= IRQ_MASK_RST;
      irq_ff      <= 1'b0;
    end else if (ce) begin
      aw_held_ff  <= nxt_aw_held;
      w_held_ff   <= nxt_w_held;
      waddr_ff    <= nxt_waddr;
      wbyte_ff    <= nxt_wbyte;
      wlane_ff    <= nxt_wlane;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      arready_ff  <= nxt_arready;
      rvalid_ff   <= nxt_rvalid;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
      ctrl_ff     <= nxt_ctrl;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff      <= nxt_irq;
    end
  end

  assign s_axi_awready            = awready_ff;
  assign s_axi_wready             = wready_ff;
  assign s_axi_bvalid             = bvalid_ff;
  assign s_axi_bresp              = bresp_ff;
  assign s_axi_arready            = arready_ff;
  assign s_axi_rvalid             = rvalid_ff;
  assign s_axi_rdata              = rdata_ff;
  assign s_axi_rresp              = rresp_ff;
  assign block_done               = done_ff;
  assign first_status_byte        = fs_ff;
  assign block_number_status_byte = num_ff;
  assign vert_correct_en          = vce_ff;
  assign interleave_en            = ilv_ff;
  assign method                   = meth_ff;
  assign irq                      = irq_ff;
endmodule

/* File: fmf_pkg.sv */
/*
  Shared constants for the FM multiplex frame-format controller: register map,
  control and status bit positions, frame layout, block field sizes and timing.
  Assumes a single 50 MHz clock shared with the decoder core.
*/
package fmf_pkg;
  localparam int CLK_HZ = 50_000_000;

  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] ADDR_CTRL     = 4'h0;
  localparam logic [AXI_AW-1:0] ADDR_STATE    = 4'h4;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_MASK = 4'hC;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CTRL_INTERLEAVE_BIT = 0;
  localparam int CTRL_REALTIME_BIT   = 1;
  localparam int CTRL_HALT_BIT       = 2;
  localparam logic [2:0] CTRL_RST    = 3'h0;

  localparam int FS_REALTIME_INFO_BLOCK_BIT   = 0;
  localparam int FS_HEAD_BIT   = 2;
  localparam int FS_PARITY_BIT = 3;
  localparam int FS_SYNC_BIT   = 5;

  localparam int EV_BLOCK   = 0;
  localparam int EV_HEAD    = 1;
  localparam int EV_SYNC    = 2;
  localparam int EV_TIMEOUT = 3;
  localparam int EV_N       = 4;
  localparam logic [EV_N-1:0] IRQ_MASK_RST = 4'h0;

  localparam int FRAME_BLOCKS  = 284;
  localparam int DATA_BLOCKS   = 190;
  localparam int DATA_G1_END   = 60;
  localparam int DATA_G2_END   = 130;
  localparam int PAR_G1        = 20;
  localparam int PAR_G2        = 21;
  localparam int PAR_G3        = 21;
  localparam int PAR_G4        = 20;
  localparam int REALTIME_INFO_BLOCK_GROUP    = 4;
  localparam int VERT_PACKETS  = 272;
  localparam int REALTIME_INFO_BLOCK_PACKETS  = 12;
  localparam int POS_W         = 9;

  localparam int ID_BITS   = 16;
  localparam int INFO_BITS = 176;
  localparam int CRC_BITS  = 14;
  localparam int HPAR_BITS = 82;
  localparam int CNT_W     = 8;

  localparam int BLOCK_PERIOD_MS     = 18;
  localparam int FRAME_PERIOD_MS     = 5112;
  localparam int BLOCK_PERIOD_CYC_DEF = BLOCK_PERIOD_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    METH_A  = 2'b00,
    METH_A2 = 2'b01,
    METH_B  = 2'b10,
    METH_C  = 2'b11
  } fmf_method_t;

  typedef enum logic [1:0] {
    KIND_DATA   = 2'b00,
    KIND_PARITY = 2'b01,
    KIND_REALTIME_INFO_BLOCK   = 2'b10
  } fmf_kind_t;

  typedef enum logic [1:0] {
    PS_ID   = 2'b00,
    PS_INFO = 2'b01,
    PS_CRC  = 2'b10,
    PS_PAR  = 2'b11
  } fmf_parse_t;
endpackage

/* File: fmf_frame_map.sv */
/*
  Frame layout map: turns a block position within the 284-block frame into its
  kind, its expected identification code class and its data or parity number.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/100ps
module fmf_frame_map (
  input  wire logic [fmf_pkg::POS_W-1:0] pos,
  output fmf_pkg::fmf_kind_t             kind,
  output logic [2:0]                     exp_code,
  output logic [7:0]                     number
);
  import fmf_pkg::*;

  localparam int P1S = DATA_BLOCKS;
  localparam int R1S = P1S + PAR_G1;
  localparam int P2S = R1S + REALTIME_INFO_BLOCK_GROUP;
  localparam int R2S = P2S + PAR_G2;
  localparam int P3S = R2S + REALTIME_INFO_BLOCK_GROUP;
  localparam int R3S = P3S + PAR_G3;
  localparam int P4S = R3S + REALTIME_INFO_BLOCK_GROUP;

  int p;

  always_comb begin
    p        = int'(pos);
    kind     = KIND_PARITY;
    exp_code = 3'h4;
    number   = 8'h00;
    if (p < DATA_G1_END) begin
      kind     = KIND_DATA;
      exp_code = 3'h3;
      number   = 8'(p + 1);
    end else if (p < DATA_G2_END) begin
      kind     = KIND_DATA;
      exp_code = 3'h2;
      number   = 8'(p + 1);
    end else if (p < DATA_BLOCKS) begin
      kind     = KIND_DATA;
      exp_code = 3'h1;
      number   = 8'(p + 1);
    end else if ((p >= R1S && p < P2S) || (p >= R2S && p < P3S) || (p >= R3S && p < P4S)) begin
      kind     = KIND_REALTIME_INFO_BLOCK;
      exp_code = 3'h2;
    end else if (p < R1S) begin
      number = 8'(p - P1S + 1);
    end else if (p < R2S) begin
      number = 8'(p - P2S + PAR_G1 + 1);
    end else if (p < R3S) begin
      number = 8'(p - P3S + PAR_G1 + PAR_G2 + 1);
    end else begin
      number = 8'(p - P4S + PAR_G1 + PAR_G2 + PAR_G3 + 1);
    end
  end
endmodule

/* File: fmf_frame_ctrl_monitor.sv */
/*
  Checker for the frame-format controller: concurrent assertions on its ports.
  Assumes one clock, synchronous active-high reset and ce held high.
*/
`timescale 1ns/100ps
module fmf_frame_ctrl_monitor (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 bit_valid,
  input wire logic                 block_done,
  input wire logic [7:0]           first_status_byte,
  input wire logic [7:0]           block_number_status_byte,
  input wire logic                 vert_correct_en,
  input wire logic                 interleave_en,
  input wire logic [1:0]           method,
  input wire logic                 irq
);
  import fmf_pkg::*;
  // Age of the last write-data handshake; the method may only move shortly after one.
  logic [2:0] wr_age_ff;
  logic [2:0] nxt_wr_age;
  always_comb begin
    nxt_wr_age = (wr_age_ff == 3'h7) ? 3'h7 : wr_age_ff + 3'h1;
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wr_age = 3'h0;
    end
    if (reset) begin
      nxt_wr_age = 3'h7;
    end
  end
  always_ff @(posedge clk) begin
    wr_age_ff <= nxt_wr_age;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence c_done;
    block_done && method == METH_C && $past(method) == METH_C;
  endsequence
  a_reset_method: assert property (disable iff (1'b0) reset |=> method == METH_B && interleave_en)
    else $error("method is not B after reset");
  a_method_by_host: assert property ($changed(method) |-> wr_age_ff <= 3'h5)
    else $error("method changed without a register write");
  a_interleave_b: assert property ($stable(method) |-> interleave_en == (method == METH_B))
    else $error("interleave enable disagrees with method");
  a_c_no_vert: assert property (c_done |-> !vert_correct_en)
    else $error("vertical correction on in method C");
  a_c_frame_flags: assert property (c_done |-> (first_status_byte & 8'h25) == 8'h00)
    else $error("frame flags set in method C");
  a_c_block_num: assert property (c_done |-> !first_status_byte[3] && block_number_status_byte == 8'h00)
    else $error("parity flag or block number set in method C");
  a_parity_range: assert property (block_done && first_status_byte[FS_PARITY_BIT]
    |-> block_number_status_byte inside {[8'h01:8'h52]})
    else $error("parity number out of range");
  a_realtime_info_block_no_vert: assert property (block_done && first_status_byte[FS_REALTIME_INFO_BLOCK_BIT] |-> !vert_correct_en)
    else $error("real-time block marked for vertical correction");
  a_done_cause: assert property (block_done |-> $past(bit_valid))
    else $error("block end without a received bit");
  a_done_spacing: assert property (block_done |=> !block_done [*8])
    else $error("block ends too close together");
  c_head: cover property (block_done && first_status_byte[FS_HEAD_BIT]);
  c_meth_c: cover property (c_done);
  c_irq: cover property ($rose(irq));
endmodule

bind fmf_frame_ctrl fmf_frame_ctrl_monitor mon_u (
  .clk(clk), .reset(reset), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .bit_valid(bit_valid), .block_done(block_done), .first_status_byte(first_status_byte),
  .block_number_status_byte(block_number_status_byte), .vert_correct_en(vert_correct_en),
  .interleave_en(interleave_en), .method(method), .irq(irq)
);

/* File: fmf_bit_src.sv */
/*
  Received-bit source standing in for the demodulator: one 288-bit block per start pulse.
  Assumes start is raised for one cycle while the source is idle.
*/
`timescale 1ns/100ps
module fmf_bit_src (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] code,
  output logic             bit_valid,
  output logic             bit_data
);
  logic [15:0] code_ff;
  logic        tog = 1'b0;
  int          idx = 288;
  always @(posedge clk) begin
    tog <= !tog;
    if (start) begin
      code_ff <= code;
      idx     <= 0;
    end else if (idx < 288) begin
      idx <= idx + 1;
    end
  end
  // Idle line toggles so a stale bit is never mistaken for data.
  assign bit_valid = idx < 288;
  assign bit_data  = !bit_valid ? tog : (idx < 16) ? code_ff[15 - idx] : idx[0] ^ idx[3];
endmodule

/* File: testbench.sv */
/*
  Self-checking bench for the frame-format controller: AXI4-Lite register tasks and block stimulus.
  Assumes a 50 MHz clock and a shortened block period.
*/
`timescale 1ns/100ps
module testbench;
  import fmf_pkg::*;
  logic        clk, reset, ce, start, bit_valid, bit_data, block_done, vce, ile, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  fsb, bnsb;
  logic [15:0] code;
  fmf_method_t method;
  int          n_errors = 0;
  int          total_checks = 0;

  fmf_frame_ctrl #(.BLOCK_PERIOD_CYC(2000)) dut_u (
    .clk(clk), .reset(reset), .ce(ce), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .bit_valid(bit_valid),
    .bit_data(bit_data), .block_done(block_done), .first_status_byte(fsb),
    .block_number_status_byte(bnsb), .vert_correct_en(vce), .interleave_en(ile), .method(method), .irq(irq)
  );
  fmf_bit_src src_u (.clk(clk), .start(start), .code(code), .bit_valid(bit_valid), .bit_data(bit_data));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    // The slave answers when it is ready; only the watchdog ends a wait that never ends.
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    check(bresp, RESP_OKAY);
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    check(rresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR);
  endtask

  task automatic send_block(input logic [15:0] c);
    @(posedge clk);
    code  <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    do begin
      @(posedge clk);
    end while (!block_done);
  endtask

  initial begin
    logic [31:0] rd;
    logic [15:0] bc;
    fmf_method_t em;
    {reset, ce, wstrb} = 6'h3F;
    {start, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, code} = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    check(method, METH_B);
    check(ile, 1'b1);
    axi_read(ADDR_CTRL, rd);
    check(rd, 32'h0);
    axi_read(4'h2, rd);
    check(rd, 32'h0);
    for (int v = 0; v < 8; v++) begin
      axi_write(ADDR_CTRL, v);
      repeat (2) @(posedge clk);
      em = v[2] ? METH_C : !v[0] ? METH_B : v[1] ? METH_A : METH_A2;
      check(method, em);
      check(ile, em == METH_B);
      axi_read(ADDR_CTRL, rd);
      check(rd, v);
    end
    axi_write(ADDR_CTRL, 32'h0);
    axi_write(ADDR_IRQ_MASK, 32'h1);
    send_block(16'h4444);
    send_block(16'h3333);
    check(fsb, 8'h24);
    check(bnsb, 8'h01);
    check(vce, 1'b1);
    axi_read(ADDR_STATE, rd);
    check(rd, 32'h0000_0006);
    check(irq, 1'b1);
    axi_read(ADDR_IRQ_STAT, rd);
    check(rd[0], 1'b1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    for (int i = 2; i <= 60; i++) begin
      send_block(16'h3333);
      check(bnsb, i);
    end
    send_block(16'h2222);
    check(fsb, 8'h20);
    check(bnsb, 8'h3D);
    // Method C while the frame is still locked, with the interrupt masked.
    axi_write(ADDR_IRQ_MASK, 32'h0);
    axi_write(ADDR_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    send_block(16'h2222);
    check(fsb, 8'h00);
    check(bnsb, 8'h00);
    check(vce, 1'b0);
    check(irq, 1'b0);
    // Back to method B and on through the first parity group into the first real-time group.
    axi_write(ADDR_CTRL, 32'h0);
    for (int p = 62; p <= DATA_BLOCKS + PAR_G1; p++) begin
      bc = (p < DATA_G2_END || p == DATA_BLOCKS + PAR_G1) ? 16'h2222 : p < DATA_BLOCKS ? 16'h1111 : 16'h4444;
      send_block(bc);
      check(fsb, p < DATA_BLOCKS ? 8'h20 : p < DATA_BLOCKS + PAR_G1 ? 8'h28 : 8'h21);
      check(bnsb, p < DATA_BLOCKS ? p + 1 : p < DATA_BLOCKS + PAR_G1 ? p - DATA_BLOCKS + 1 : 0);
      check(vce, p < DATA_BLOCKS + PAR_G1);
    end
    // A first-code block where a real-time block belongs drops frame sync.
    send_block(16'h1111);
    check(fsb, 8'h01);
    check(vce, 1'b0);
    test_done();
  end

  // The run needs some 63000 cycles; 80000 means a hang.
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule
